/* File: sim/rppm_endpoint.sv */
// Behavioural endpoint on the downstream link of the port.
module rppm_endpoint (
  input  wire logic                     mclk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     turn_off_in,  // Turn-off message seen on the link.
  input  wire logic                     pme_go_in,    // Bench asks for one PME message.
  input  wire logic [15:0]              pme_rid_in,   // Requester ID to carry.
  output logic                          ack_out,      // Turn-off acknowledge.
  output rppm_pkg::rppm_link_state_s    link_out,     // Link state toward the port.
  output rppm_pkg::rppm_pme_msg_s       pme_out,      // PME message strobe.
  output logic                          ltr_out       // Latency tolerance report strobe.
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt_q;       // Cycles since the turn-off message, -1 before the first one, then held at 8.
  logic ltr_done_q;  // Boot report already sent.

  // The model's tolerance never changes, so only the boot report is sent.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ltr_done_q <= 1'b0;
      ltr_out    <= 1'b0;
    end else begin
      ltr_done_q <= 1'b1;
      ltr_out    <= ~ltr_done_q;
    end
  end

  // Acknowledge first, then ask for L23 a few cycles later, whatever the prior state.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q    <= -1;
      ack_out  <= 1'b0;
      link_out <= 5'h01;
    end else begin
      if (turn_off_in) cnt_q <= 0;
      else if (cnt_q >= 0 && cnt_q < 8) cnt_q <= cnt_q + 1;
      ack_out <= (cnt_q == 2);
      if (cnt_q == 7) link_out.l23 <= 1'b1;
    end
  end

  // One strobe per request; the ID lines toggle while no message is offered.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pme_out <= 17'h00000;
    end else begin
      pme_out.valid <= pme_go_in;
      pme_out.rid   <= pme_go_in ? pme_rid_in : ~pme_out.rid;
    end
  end
endmodule // rppm_endpoint

/* File: sim/rppm_top_test.sv */
// Self-checking bench: APB register calls plus link-side stimulus.
module rppm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sleep = 0, wake_n = 1, go = 0, eq = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic rdy, err, slv, ack, to, l23r, wk, msi, intx, gpe, sci, smi_n, claim, fwd, ltr;
  logic [15:0] rid = 16'h0;
  logic [3:0] sev = 4'h0;
  rppm_pkg::rppm_link_state_s lnk;
  rppm_pkg::rppm_pme_msg_s pme;
  rppm_pkg::rppm_throttle_s thr;
  rppm_pkg::rppm_io_req_s io = 18'h0;
  int n_errors = 0, n_checks = 0, n_msi = 0, n_gpe = 0, n_wake = 0, n_ltr = 0;

  rppm_top dut (.mclk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
    .sleep_entry_req_in(sleep), .turn_off_send_out(to), .l23_reached_out(l23r), .rx_pme_to_ack_in(ack),
    .link_in(lnk), .wake_n_in(wake_n), .wake_to_pmc_out(wk), .pme_msg_in(pme), .msi_send_out(msi),
    .intx_out(intx), .gpe_msg_out(gpe), .sci_out(sci), .system_mgmt_interrupt_n_out(smi_n),
    .link_eq_req_in(eq), .throttle_severity_in(sev), .throttle_out(thr), .io_req_in(io),
    .io_claim_out(claim), .io_forward_out(fwd));
  rppm_endpoint ep (.mclk_in(clk), .rst_n_in(rst_n), .turn_off_in(to), .pme_go_in(go),
    .pme_rid_in(rid), .ack_out(ack), .link_out(lnk), .pme_out(pme), .ltr_out(ltr));

  // Clock of 100 MHz.
  always #5 clk = ~clk;

  // One-cycle pulses are counted at the edge that sees them.
  always @(posedge clk) begin
    n_msi  += (msi === 1'b1);
    n_gpe  += (gpe === 1'b1);
    n_wake += (wk === 1'b1);
    n_ltr  += (ltr === 1'b1);
  end

  // Compares a value with its expectation.
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer held until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    slv = err;
    psel <= 0; pen <= 0;
  endtask

  // Sends one PME message through the endpoint and lets it land.
  task send_pme(input logic [15:0] r);
    @(posedge clk);
    go <= 1; rid <= r;
    @(posedge clk);
    go <= 0;
    repeat (4) @(posedge clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #200us;
    n_errors++;
    test_done;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    apb(0, 8'h08, 32'h0); chk("tp_tt", 32'h00100100, rd);
    apb(0, 8'h0C, 32'h0); chk("mult", 32'h00004321, rd);
    apb(0, 8'h10, 32'h0); chk("slverr", 32'h1, {31'h0, slv});
    // Logged PME with interrupt disabled goes to the power controller.
    apb(1, 8'h00, 32'h0000000C);
    send_pme(16'h1234);
    apb(0, 8'h04, 32'h0); chk("status", 32'h1234000D, rd);
    chk("gpe", 32'h1, n_gpe);
    chk("sci_smi", 32'h2, {sci, smi_n});
    apb(1, 8'h00, 32'h0000000F);
    repeat (2) @(posedge clk);
    chk("msi_pie", 32'h1, n_msi);
    send_pme(16'h5678);
    apb(0, 8'h04, 32'h0); chk("pend", 32'h1234000F, rd);
    chk("msi_pend", 32'h1, n_msi);
    apb(1, 8'h04, 32'h00000001);
    apb(0, 8'h04, 32'h0); chk("reload", 32'h5678000D, rd);
    // Wire mode: the pin follows the logged status.
    apb(1, 8'h00, 32'h0000000D);
    @(posedge clk);
    chk("intx", 32'h1, intx);
    // Wake is forwarded once and never logged.
    wake_n <= 0;
    repeat (5) @(posedge clk);
    wake_n <= 1;
    chk("wake", 32'h1, n_wake);
    apb(0, 8'h04, 32'h0); chk("wake_log", 32'h5678000D, rd);
    chk("msi_reload", 32'h2, n_msi);
    // Equalization request at 8 Gb/s routed to both SCI and SMI status.
    apb(1, 8'h00, 32'h000000C0);
    eq <= 1;
    @(posedge clk);
    eq <= 0;
    apb(0, 8'h04, 32'h0); chk("eq", 32'h5678003D, rd);
    // Sleep entry waits for L23.
    sleep <= 1;
    @(posedge clk);
    sleep <= 0;
    repeat (3) @(posedge clk);
    chk("early_l23", 32'h0, l23r);
    repeat (12) @(posedge clk);
    chk("l23", 32'h1, l23r);
    // Post-code window edges.
    apb(1, 8'h00, 32'h00000010);
    // Addresses 7Fh, 80h, 8Fh and 90h in turn.
    for (int i = 0; i < 4; i++) begin
      io <= {2'b11, 16'h007F + 16'(i == 1) + 16'(i == 2) * 16'h10 + 16'(i == 3) * 16'h11};
      @(posedge clk);
      #1 chk("claim", {30'h0, {2{i == 1 || i == 2}}}, {30'h0, claim, fwd});
    end
    io <= 18'h0;
    // Throttle zone of 16 cycles at severity 0.
    apb(1, 8'h00, 32'h00000020);
    sev <= 4'h1;
    repeat (3) @(posedge clk);
    chk("thr_on", 32'h7, thr);
    repeat (20) @(posedge clk);
    chk("thr_off", 32'h0, thr);
    // Severities 0 and 2 together pick multiplier three: a zone of 48 cycles.
    sev <= 4'h5;
    repeat (40) @(posedge clk);
    chk("thr_sev2", 32'h7, thr);
    repeat (15) @(posedge clk);
    chk("thr_sev2_off", 32'h0, thr);
    sev <= 4'h0;
    repeat (3) @(posedge clk);
    chk("thr_none", 32'h0, thr);
    chk("ltr", 32'h1, n_ltr);
    test_done;
  end
endmodule // rppm_top_test

/* File: verilog/rppm_cfg.svh */
`ifndef RPPM_CFG_SVH
`define RPPM_CFG_SVH

// Register byte offsets on the APB slave.
`define RPPM_OFS_CTRL      8'h00
`define RPPM_OFS_STATUS    8'h04
`define RPPM_OFS_THROTTLE  8'h08
`define RPPM_OFS_MULT      8'h0C

// Control register bit positions.
`define RPPM_CTRL_PIE      0
`define RPPM_CTRL_MSIE     1
`define RPPM_CTRL_SCIE     2
`define RPPM_CTRL_SMIE     3
`define RPPM_CTRL_P8XE     4
`define RPPM_CTRL_THRE     5
`define RPPM_CTRL_EQSCIE   6
`define RPPM_CTRL_EQSMIE   7
`define RPPM_CTRL_W        8

// Status register bit positions; the requester ID sits in the upper half.
`define RPPM_STS_PS        0
`define RPPM_STS_PP        1
`define RPPM_STS_SCI       2
`define RPPM_STS_SMI       3
`define RPPM_STS_EQSCI     4
`define RPPM_STS_EQSMI     5
`define RPPM_STS_RID_LSB   16

// Post-code I/O window, upper twelve address bits of 0x0080 to 0x008F.
`define RPPM_P8X_HI        12'h008

// Reset values.
`define RPPM_CTRL_RST      8'h00
`define RPPM_TP_RST        16'h0100
`define RPPM_TT_RST        16'h0010
`define RPPM_MULT_RST      16'h4321

`endif

/* File: verilog/rppm_pkg.sv */
package rppm_pkg;

  // A PM_PME message from the link: strobe and requester ID.
  typedef struct packed {
    logic        valid;
    logic [15:0] rid;
  } rppm_pme_msg_s;

  // An I/O cycle offered for decode.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } rppm_io_req_s;

  // Link state reported by the LTSSM.
  typedef struct packed {
    logic l1;
    logic l23_rdy;
    logic l23;
    logic down;
    logic rate_8g;
  } rppm_link_state_s;

  // Traffic gating toward the transmit path.
  typedef struct packed {
    logic block_tlp;
    logic block_opp_fc;
    logic hold_credits;
  } rppm_throttle_s;

  // Sleep entry sequencer states.
  typedef enum logic [1:0] {
    RPPM_SLP_IDLE,
    RPPM_SLP_SEND,
    RPPM_SLP_WAIT,
    RPPM_SLP_DONE
  } rppm_sleep_e;

endpackage

/* File: verilog/rppm_top.sv */
`include "rppm_cfg.svh"

module rppm_top #(
  parameter int TP_W   = 16,  // Width of the window period and zone time fields.
  parameter int MULT_W = 4    // Width of each severity multiplier.
) (
  input  wire logic                       mclk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [7:0]                 paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  input  wire logic                       sleep_entry_req_in,
  output logic                            turn_off_send_out,
  output logic                            l23_reached_out,
  input  wire logic                       rx_pme_to_ack_in,
  input  wire rppm_pkg::rppm_link_state_s link_in,
  input  wire logic                       wake_n_in,
  output logic                            wake_to_pmc_out,
  input  wire rppm_pkg::rppm_pme_msg_s    pme_msg_in,
  output logic                            msi_send_out,
  output logic                            intx_out,
  output logic                            gpe_msg_out,
  output logic                            sci_out,
  output logic                            system_mgmt_interrupt_n_out,
  input  wire logic                       link_eq_req_in,
  input  wire logic [3:0]                 throttle_severity_in,
  output rppm_pkg::rppm_throttle_s        throttle_out,
  input  wire rppm_pkg::rppm_io_req_s     io_req_in,
  output logic                            io_claim_out,
  output logic                            io_forward_out
);

  // Reset synchroniser: the second flop is the design-wide reset.
  logic rst_meta_q;  // First stage, read only by the second.
  logic rst_n;       // Released reset.

  // Asynchronous assertion, release through two flops.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ---------------- APB slave ----------------
  logic [`RPPM_CTRL_W-1:0] ctrl_q;       // Enables written by software.
  logic [TP_W-1:0]         tp_q;         // Throttling window period.
  logic [TP_W-1:0]         tt_q;         // Throttling zone time.
  logic [4*MULT_W-1:0]     mult_q;       // Four severity multipliers.
  logic [31:0]             prdata_q;     // Read data captured at setup.
  logic                    unmapped_q;   // Setup address hit no register.
  logic                    setup;        // Setup phase of a transfer.
  logic                    access;       // Access phase; always completes.
  logic                    wr_ctrl;      // Control write taking effect.
  logic                    wr_sts;       // Status write taking effect.
  logic                    mapped;       // Current address is a register.
  logic [31:0]             status_word;  // Assembled status for reads.

  assign setup  = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign mapped = (paddr_in == `RPPM_OFS_CTRL) || (paddr_in == `RPPM_OFS_STATUS) ||
                  (paddr_in == `RPPM_OFS_THROTTLE) || (paddr_in == `RPPM_OFS_MULT);
  assign wr_ctrl = access & pwrite_in & (paddr_in == `RPPM_OFS_CTRL);
  assign wr_sts  = access & pwrite_in & (paddr_in == `RPPM_OFS_STATUS);

  // The slave never inserts wait states.
  assign pready_out  = 1'b1;
  assign pslverr_out = access & unmapped_q;
  assign prdata_out  = prdata_q;

  // Read data and decode result are captured in the setup cycle.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q   <= 32'h0000_0000;
      unmapped_q <= 1'b0;
    end else if (setup) begin
      unmapped_q <= ~mapped;
      case (paddr_in)
        `RPPM_OFS_CTRL:     prdata_q <= {{(32-`RPPM_CTRL_W){1'b0}}, ctrl_q};
        `RPPM_OFS_STATUS:   prdata_q <= status_word;
        `RPPM_OFS_THROTTLE: prdata_q <= {tt_q, tp_q};
        `RPPM_OFS_MULT:     prdata_q <= {16'h0000, mult_q};
        default:            prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers take writes in the access cycle.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `RPPM_CTRL_RST;
      tp_q   <= `RPPM_TP_RST;
      tt_q   <= `RPPM_TT_RST;
      mult_q <= `RPPM_MULT_RST;
    end else if (access && pwrite_in) begin
      if (paddr_in == `RPPM_OFS_CTRL) begin
        ctrl_q <= pwdata_in[`RPPM_CTRL_W-1:0];
      end
      if (paddr_in == `RPPM_OFS_THROTTLE) begin
        tp_q <= pwdata_in[15:0];
        tt_q <= pwdata_in[31:16];
      end
      if (paddr_in == `RPPM_OFS_MULT) begin
        mult_q <= pwdata_in[15:0];
      end
    end
  end

  // Named views of the control bits.
  logic pme_interrupt_enable;
  logic msi_enable_bit;
  logic pm_sci_enable;
  logic pm_smi_enable;
  logic post_code_decode_enable;
  logic throttle_enable;
  assign pme_interrupt_enable    = ctrl_q[`RPPM_CTRL_PIE];
  assign msi_enable_bit          = ctrl_q[`RPPM_CTRL_MSIE];
  assign pm_sci_enable           = ctrl_q[`RPPM_CTRL_SCIE];
  assign pm_smi_enable           = ctrl_q[`RPPM_CTRL_SMIE];
  assign post_code_decode_enable = ctrl_q[`RPPM_CTRL_P8XE];
  assign throttle_enable         = ctrl_q[`RPPM_CTRL_THRE];

  // ---------------- Sleep entry ----------------
  rppm_pkg::rppm_sleep_e slp_q;  // Sequencer state.

  // The acknowledge carries no meaning here and is deliberately unused.
  logic ack_unused;
  assign ack_unused = rx_pme_to_ack_in;

  // Turn-off is sent on a request seen in the idle state, whatever the link state.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      slp_q <= rppm_pkg::RPPM_SLP_IDLE;
    end else begin
      case (slp_q)
        rppm_pkg::RPPM_SLP_IDLE: if (sleep_entry_req_in) slp_q <= rppm_pkg::RPPM_SLP_SEND;
        rppm_pkg::RPPM_SLP_SEND: slp_q <= rppm_pkg::RPPM_SLP_WAIT;
        rppm_pkg::RPPM_SLP_WAIT: if (link_in.l23) slp_q <= rppm_pkg::RPPM_SLP_DONE;
        rppm_pkg::RPPM_SLP_DONE: if (!link_in.l23) slp_q <= rppm_pkg::RPPM_SLP_IDLE;
        default:                 slp_q <= rppm_pkg::RPPM_SLP_IDLE;
      endcase
    end
  end

  // The turn-off strobe is one cycle in the send state.
  assign turn_off_send_out = (slp_q == rppm_pkg::RPPM_SLP_SEND);
  // Ready only while the link really sits in L23.
  assign l23_reached_out   = (slp_q == rppm_pkg::RPPM_SLP_DONE) & link_in.l23;

  // ---------------- Wake ----------------
  logic wake_prev_q;  // Last wake level, high when idle.
  logic wake_q;       // One-cycle wake indication.

  // Falling wake input gives a single indication and nothing else.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      wake_prev_q <= 1'b1;
      wake_q      <= 1'b0;
    end else begin
      wake_prev_q <= wake_n_in;
      wake_q      <= wake_prev_q & ~wake_n_in;
    end
  end
  assign wake_to_pmc_out = wake_q;

  // ---------------- PME logging ----------------
  logic        pme_status_flag;       // First message logged.
  logic        pme_pending_flag;      // Further message waiting.
  logic [15:0] pme_requester_id_log;  // ID reported to software.
  logic [15:0] pme_queue_q;           // Oldest waiting ID.
  logic        ps_d;
  logic        pp_d;
  logic [15:0] rid_d;
  logic [15:0] queue_d;
  logic        pme_event;             // A message became visible to software.
  logic        ps_clr;                // Software clears the status flag.

  assign ps_clr = wr_sts & pwdata_in[`RPPM_STS_PS];

  // A message arriving with the clear is never lost.
  always_comb begin
    ps_d      = pme_status_flag;
    pp_d      = pme_pending_flag;
    rid_d     = pme_requester_id_log;
    queue_d   = pme_queue_q;
    pme_event = 1'b0;
    if (ps_clr && pme_pending_flag) begin
      ps_d      = 1'b1;
      pp_d      = 1'b0;
      rid_d     = pme_queue_q;
      pme_event = 1'b1;
      if (pme_msg_in.valid) begin
        pp_d    = 1'b1;
        queue_d = pme_msg_in.rid;
      end
    end else if (pme_msg_in.valid && (ps_clr || !pme_status_flag)) begin
      ps_d      = 1'b1;
      rid_d     = pme_msg_in.rid;
      pme_event = 1'b1;
    end else if (pme_msg_in.valid) begin
      pp_d = 1'b1;
      if (!pme_pending_flag) begin
        queue_d = pme_msg_in.rid;
      end
    end else if (ps_clr) begin
      ps_d = 1'b0;
    end
  end

  // PME log registers.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pme_status_flag      <= 1'b0;
      pme_pending_flag     <= 1'b0;
      pme_requester_id_log <= 16'h0000;
      pme_queue_q          <= 16'h0000;
    end else begin
      pme_status_flag      <= ps_d;
      pme_pending_flag     <= pp_d;
      pme_requester_id_log <= rid_d;
      pme_queue_q          <= queue_d;
    end
  end

  // ---------------- Interrupt, GPE, SCI, SMI ----------------
  logic pie_rise;     // Interrupt enable written from zero to one.
  logic msi_q;        // One-cycle MSI request.
  logic gpe_q;        // One-cycle GPE message.
  logic pm_sci_status;
  logic pm_smi_status;
  logic eq_sci_q;     // Equalization request routed to SCI.
  logic eq_smi_q;     // Equalization request routed to SMI.
  logic eq_event;     // Equalization request at 8 Gb/s.

  assign pie_rise = wr_ctrl & pwdata_in[`RPPM_CTRL_PIE] & ~pme_interrupt_enable;
  assign eq_event = link_eq_req_in & link_in.rate_8g;

  // Message and GPE strobes.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      msi_q <= 1'b0;
      gpe_q <= 1'b0;
    end else begin
      // The enable rise honours the MSI bit written in the same control word.
      msi_q <= (msi_enable_bit & pme_event & pme_interrupt_enable) |
               (pwdata_in[`RPPM_CTRL_MSIE] & pie_rise & pme_status_flag);
      gpe_q <= pme_event & ~pme_interrupt_enable;
    end
  end

  // Sticky routing status, write one to clear; a new event wins.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pm_sci_status <= 1'b0;
      pm_smi_status <= 1'b0;
      eq_sci_q      <= 1'b0;
      eq_smi_q      <= 1'b0;
    end else begin
      pm_sci_status <= (pm_sci_status & ~(wr_sts & pwdata_in[`RPPM_STS_SCI])) |
                       (pme_event & pm_sci_enable);
      pm_smi_status <= (pm_smi_status & ~(wr_sts & pwdata_in[`RPPM_STS_SMI])) |
                       (pme_event & pm_smi_enable);
      eq_sci_q      <= (eq_sci_q & ~(wr_sts & pwdata_in[`RPPM_STS_EQSCI])) |
                       (eq_event & ctrl_q[`RPPM_CTRL_EQSCIE]);
      eq_smi_q      <= (eq_smi_q & ~(wr_sts & pwdata_in[`RPPM_STS_EQSMI])) |
                       (eq_event & ctrl_q[`RPPM_CTRL_EQSMIE]);
    end
  end

  // Wire interrupt follows the status flag while enabled without MSI.
  assign intx_out     = pme_interrupt_enable & ~msi_enable_bit & pme_status_flag;
  assign msi_send_out = msi_q;
  assign gpe_msg_out  = gpe_q;
  assign sci_out      = pm_sci_status | eq_sci_q;
  assign system_mgmt_interrupt_n_out = ~(pm_smi_status | eq_smi_q);

  assign status_word = {pme_requester_id_log, 10'h000, eq_smi_q, eq_sci_q,
                        pm_smi_status, pm_sci_status, pme_pending_flag, pme_status_flag};

  // ---------------- Dynamic link throttling ----------------
  logic [MULT_W-1:0]      mult [4];     // Multiplier per severity level.
  logic [3:0]             sev_prev_q;   // Severity seen last cycle.
  logic                   thr_en_q;     // Enable seen last cycle.
  logic [TP_W-1:0]        win_cnt_q;    // Position in the window.
  logic [1:0]             sev_idx;      // Highest active severity.
  logic                   sev_any;      // Any severity active.
  logic                   paused;       // Link state stops the timers.
  logic                   restart;      // Window starts again from zero.
  logic [TP_W+MULT_W-1:0] zone_len;     // Throttling zone in cycles.
  logic                   in_zone;
  logic                   throttling;

  for (genvar g = 0; g < 4; g++) begin : g_mult
    assign mult[g] = mult_q[g*MULT_W +: MULT_W];
  end

  // Pick the highest severity that is currently raised.
  always_comb begin
    sev_idx = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (throttle_severity_in[i]) sev_idx = i[1:0];
    end
  end

  assign sev_any  = |throttle_severity_in;
  assign paused   = link_in.l1 | link_in.l23_rdy | link_in.down;
  assign restart  = (throttle_severity_in != sev_prev_q) | (throttle_enable & ~thr_en_q) | paused;
  assign zone_len = tt_q * mult[sev_idx];
  assign in_zone  = {{MULT_W{1'b0}}, win_cnt_q} < zone_len;

  // Window counter wraps at the programmed period.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_q  <= '0;
      sev_prev_q <= 4'h0;
      thr_en_q   <= 1'b0;
    end else begin
      sev_prev_q <= throttle_severity_in;
      thr_en_q   <= throttle_enable;
      // A zero period behaves as a period of one cycle.
      if (restart || (tp_q == '0) || (win_cnt_q >= tp_q - 1'b1)) begin
        win_cnt_q <= '0;
      end else begin
        win_cnt_q <= win_cnt_q + 1'b1;
      end
    end
  end

  // Gate only inside the zone while enabled with a severity raised.
  assign throttling = throttle_enable & sev_any & ~paused & in_zone;
  assign throttle_out.block_tlp    = throttling;
  assign throttle_out.block_opp_fc = throttling;
  assign throttle_out.hold_credits = throttling;

  // ---------------- Post-code decode ----------------
  assign io_claim_out   = post_code_decode_enable & io_req_in.valid &
                          (io_req_in.addr[15:4] == `RPPM_P8X_HI);
  assign io_forward_out = io_claim_out;

  // ---------------- Checks ----------------
  property p_turn_off;
    @(posedge mclk_in) disable iff (!rst_n)
    (slp_q == rppm_pkg::RPPM_SLP_IDLE) && sleep_entry_req_in |=> turn_off_send_out ##1 !turn_off_send_out;
  endproperty
  a_turn_off: assert property (p_turn_off) else $error("turn-off not sent");

  property p_l23;
    @(posedge mclk_in) disable iff (!rst_n)
    l23_reached_out |-> link_in.l23 && $past(slp_q) != rppm_pkg::RPPM_SLP_IDLE;
  endproperty
  a_l23: assert property (p_l23) else $error("ready without L23");

  property p_wake;
    @(posedge mclk_in) disable iff (!rst_n)
    $fell(wake_n_in) |=> wake_to_pmc_out ##1 !wake_to_pmc_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not forwarded");

  property p_first_pme;
    @(posedge mclk_in) disable iff (!rst_n)
    pme_msg_in.valid && !pme_status_flag |=> pme_status_flag && pme_requester_id_log == $past(pme_msg_in.rid);
  endproperty
  a_first_pme: assert property (p_first_pme) else $error("first PME not logged");

  property p_pending;
    @(posedge mclk_in) disable iff (!rst_n)
    pme_msg_in.valid && pme_status_flag && !ps_clr |=> pme_pending_flag && $stable(pme_requester_id_log);
  endproperty
  a_pending: assert property (p_pending) else $error("pending PME mishandled");

  property p_reload;
    @(posedge mclk_in) disable iff (!rst_n)
    ps_clr && pme_pending_flag && !pme_msg_in.valid |=>
      pme_status_flag && !pme_pending_flag && pme_requester_id_log == $past(pme_queue_q);
  endproperty
  a_reload: assert property (p_reload) else $error("queued PME not reloaded");

  property p_gpe;
    @(posedge mclk_in) disable iff (!rst_n)
    pme_event && !pme_interrupt_enable |=> gpe_msg_out && !msi_send_out;
  endproperty
  a_gpe: assert property (p_gpe) else $error("GPE message missing");

  property p_pie_rise;
    @(posedge mclk_in) disable iff (!rst_n)
    pie_rise && pme_status_flag && pwdata_in[`RPPM_CTRL_MSIE] |=> msi_send_out;
  endproperty
  a_pie_rise: assert property (p_pie_rise) else $error("no interrupt on enable");

  property p_sci;
    @(posedge mclk_in) disable iff (!rst_n)
    pme_event && pm_sci_enable |=> pm_sci_status && sci_out;
  endproperty
  a_sci: assert property (p_sci) else $error("SCI status not set");

  property p_smi;
    @(posedge mclk_in) disable iff (!rst_n)
    pme_event && pm_smi_enable |=> !system_mgmt_interrupt_n_out;
  endproperty
  a_smi: assert property (p_smi) else $error("SMI not asserted");

  property p_restart;
    @(posedge mclk_in) disable iff (!rst_n)
    (throttle_severity_in != sev_prev_q) |=> win_cnt_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("window not restarted");

  property p_no_throttle;
    @(posedge mclk_in) disable iff (!rst_n)
    !throttle_enable || !sev_any || paused |-> !throttle_out.block_tlp && !throttle_out.hold_credits;
  endproperty
  a_no_throttle: assert property (p_no_throttle) else $error("throttled while idle");

  property p_claim;
    @(posedge mclk_in) disable iff (!rst_n)
    io_req_in.valid && post_code_decode_enable && io_req_in.addr >= 16'h0080 && io_req_in.addr <= 16'h008F
      |-> io_claim_out && io_forward_out;
  endproperty
  a_claim: assert property (p_claim) else $error("post code not claimed");

  c_sleep:   cover property (@(posedge mclk_in) disable iff (!rst_n) l23_reached_out);
  c_reload:  cover property (@(posedge mclk_in) disable iff (!rst_n) ps_clr && pme_pending_flag);
  c_throttle: cover property (@(posedge mclk_in) disable iff (!rst_n) $rose(throttle_out.block_tlp));
  c_claim:   cover property (@(posedge mclk_in) disable iff (!rst_n) io_claim_out);

endmodule // rppm_top
